/* rtl/mprf_map.vh */
// Purpose: Constants for the part receive filter: register offsets, fields, codes
// Assumes: Wishbone classic, 32-bit data, byte addresses
// Notes: Included by every design file of the block
`ifndef MPRF_MAP_VH
`define MPRF_MAP_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define MPRF_CFG_ADDR 8'h00
`define MPRF_SW_ADDR 8'h04
`define MPRF_STAT_ADDR 8'h08
`define MPRF_CTRL_ADDR 8'h0C
// ----------------------------------------
// Config register fields
// ----------------------------------------
`define MPRF_CFG_CHAN_LSB 0
`define MPRF_CFG_GCHAN_LSB 5
`define MPRF_CFG_SUS_LSB 9
`define MPRF_CFG_PCF_BIT 12
`define MPRF_CFG_CCF_BIT 13
`define MPRF_CFG_GPC_BIT 14
`define MPRF_CFG_GCC_BIT 15
`define MPRF_CFG_PAT_BIT 16
`define MPRF_CFG_RESET 32'h0000_C010
// ----------------------------------------
// Switch register fields
// ----------------------------------------
`define MPRF_SW_FS1_LSB 0
`define MPRF_SW_FS3_LSB 4
`define MPRF_SW_FS3MODE_LSB 8
`define MPRF_SW_PEDRX_BIT 10
`define MPRF_SW_EN_LSB 11
`define MPRF_SW_RESET 32'h0000_3800
// ----------------------------------------
// Channel selector codes (0..15 = channel 1..16)
// ----------------------------------------
`define MPRF_CH_OMNI 5'h10
`define MPRF_CH_GLOBAL 5'h11
// ----------------------------------------
// Sustain response codes
// ----------------------------------------
`define MPRF_SUS_ENABLE 3'h0
`define MPRF_SUS_HOLD 3'h1
`define MPRF_SUS_AMUTE 3'h2
`define MPRF_SUS_PMUTE 3'h3
`define MPRF_SUS_ENABLE_I 3'h4
`define MPRF_SUS_HOLD_I 3'h5
`define MPRF_SUS_PMUTE_I 3'h6
`define MPRF_SUS_OFF 3'h7
// ----------------------------------------
// Footswitch response codes (bit 3 = inverted)
// ----------------------------------------
`define MPRF_FS_OFF 3'h0
`define MPRF_FS_SUSTAIN 3'h1
`define MPRF_FS_HOLD 3'h2
`define MPRF_FS_AMUTE 3'h3
`define MPRF_FS_PMUTE 3'h4
// ----------------------------------------
// Footswitch 3 global modes
// ----------------------------------------
`define MPRF_FS3_SWITCH 2'h0
`define MPRF_FS3_SWITCH_I 2'h1
`define MPRF_FS3_PEDAL_R 2'h2
`define MPRF_FS3_PEDAL_T 2'h3
// ----------------------------------------
// MIDI codes
// ----------------------------------------
`define MPRF_ST_NOTE_ON 4'h9
`define MPRF_ST_CC 4'hB
`define MPRF_ST_PC 4'hC
`define MPRF_CC_BANK_MSB 7'h00
`define MPRF_CC_PEDAL 7'h02
`define MPRF_CC_BANK_LSB 7'h20
`define MPRF_CC_FS1 7'h40
`define MPRF_CC_FS3 7'h42
`define MPRF_CC_ON_MIN 7'h40
`endif

/* rtl/mprf_decode.v */
// Purpose: Decode a received channel message into type, channel and data
// Assumes: Message bytes arrive already assembled, one strobe per message
// Notes: Registered outputs, one cycle of latency
`timescale 1ns/10ps
`include "mprf_map.vh"
module mprf_decode (
    // Clock and reset
    input wire clk_sys,
    input wire rst_n,
    // Message in
    input wire msg_valid,
    input wire [7:0] msg_status,
    input wire [6:0] msg_data1,
    input wire [6:0] msg_data2,
    // Decoded out
    output reg dec_valid,
    output reg [3:0] dec_type,
    output reg [3:0] dec_chan,
    output reg [6:0] dec_d1,
    output reg [6:0] dec_d2
);
    // ----------------------------------------
    // Status split
    // ----------------------------------------
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dec_valid <= 1'b0;
            dec_type <= 4'h0;
            dec_chan <= 4'h0;
            dec_d1 <= 7'h00;
            dec_d2 <= 7'h00;
        end else begin
            // Only channel voice messages carry a channel
            dec_valid <= msg_valid && msg_status[7] && (msg_status[7:4] != 4'hF);
            dec_type <= msg_status[7:4];
            dec_chan <= msg_status[3:0];
            dec_d1 <= msg_data1;
            dec_d2 <= msg_data2;
        end
    end
endmodule

/* rtl/mprf_switch_map.v */
// Purpose: Map an on/off controller event onto part actions by response code
// Assumes: Code 0 is off, bit 3 inverts polarity
// Notes: Combinational
`timescale 1ns/10ps
`include "mprf_map.vh"
module mprf_switch_map (
    // Event
    input wire ev_valid,
    input wire ev_on,
    input wire [3:0] resp,
    // Actions
    output reg set_sustain,
    output reg set_hold,
    output reg set_amute,
    output reg set_pmute,
    output wire level
);
    assign level = ev_on ^ resp[3];
    always @* begin
        set_sustain = 1'b0;
        set_hold = 1'b0;
        set_amute = 1'b0;
        set_pmute = 1'b0;
        if (ev_valid) begin
            case (resp[2:0])
                `MPRF_FS_SUSTAIN: set_sustain = 1'b1;
                `MPRF_FS_HOLD: set_hold = 1'b1;
                `MPRF_FS_AMUTE: set_amute = 1'b1;
                `MPRF_FS_PMUTE: set_pmute = 1'b1;
                default: set_sustain = 1'b0;
            endcase
        end
    end
endmodule

/* rtl/mprf_part.v */
// Purpose: Per-part MIDI receive filter and footswitch response for one synth part
// Assumes: Wishbone classic slave, 32-bit data; MIDI bytes pre-assembled into messages
// Notes: Actions are levels held in flip-flops; events are one-cycle pulses
//
// Functional notes
// - Enable mode holds envelopes while sustain on
// - Hold mode follows sustain on and off
// - Mute modes follow sustain likewise
// - Sustain selector has eight settings
// - Inverted variants swap pedal polarity
// - Channel 1 to 16, omni, global
// - Global setting matches instrument global channel
// - Omni accepts any channel
// - Page-down learn takes note channel only
// - Footswitch 1 and 3 response selectors
// - Footswitch 3 selector only in switch mode
// - Pedal mode controller 2 gated per part
// - Disabled switch enable: no effect, no transmit
// - Enabled switch acts and transmits controller
// - Part program filter discards program changes
// - Global program disable overrides all parts
// - Program filter also blocks bank select
// - Part controller filter discards controllers
// - Global controller disable overrides all parts
// - Controller filter passes bank select
// - Pattern source selects program or override
// - Channel button on sysex page starts dump
`timescale 1ns/10ps
`include "mprf_map.vh"
module mprf_part (
    // Clock and reset
    input wire clk_sys,
    input wire nrst,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // MIDI message in
    input wire msg_valid,
    input wire [7:0] msg_status,
    input wire [6:0] msg_data1,
    input wire [6:0] msg_data2,
    // Panel and local footswitches (pulses with level)
    input wire page_down_held,
    input wire sysex_page_active,
    input wire chan_button_press,
    input wire fsw_event,
    input wire [1:0] fsw_index,
    input wire fsw_on,
    input wire pedal_event,
    input wire [6:0] pedal_value,
    // Part actions
    output reg env_sustain,
    output reg arp_hold,
    output reg arp_mute,
    output reg part_mute,
    output reg prog_change_valid,
    output reg [6:0] prog_change_num,
    output reg cc_valid,
    output reg [6:0] cc_num,
    output reg [6:0] cc_value,
    output reg use_perf_pattern,
    output reg sysex_dump_start,
    // Controller transmit
    output reg tx_valid,
    output reg [7:0] tx_status,
    output reg [6:0] tx_data1,
    output reg [6:0] tx_data2
);
    // ----------------------------------------
    // Reset synchroniser
    // ----------------------------------------
    reg rst_meta;
    reg rst_n;
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg [31:0] cfg;
    reg [31:0] sw;
    wire [4:0] part_channel = cfg[`MPRF_CFG_CHAN_LSB +: 5];
    wire [3:0] global_channel = cfg[`MPRF_CFG_GCHAN_LSB +: 4];
    wire [2:0] sustain_switch2_response = cfg[`MPRF_CFG_SUS_LSB +: 3];
    wire prog_filter = cfg[`MPRF_CFG_PCF_BIT];
    wire ctrl_filter = cfg[`MPRF_CFG_CCF_BIT];
    wire global_pc_en = cfg[`MPRF_CFG_GPC_BIT];
    wire global_cc_en = cfg[`MPRF_CFG_GCC_BIT];
    wire [3:0] footswitch_one_response = sw[`MPRF_SW_FS1_LSB +: 4];
    wire [3:0] footswitch_three_response = sw[`MPRF_SW_FS3_LSB +: 4];
    wire [1:0] fs3_mode = sw[`MPRF_SW_FS3MODE_LSB +: 2];
    wire pedal_rx = sw[`MPRF_SW_PEDRX_BIT];
    wire [2:0] sw_enable = sw[`MPRF_SW_EN_LSB +: 3];
    wire fs3_is_switch = (fs3_mode == `MPRF_FS3_SWITCH) || (fs3_mode == `MPRF_FS3_SWITCH_I);

    wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wb_wr = wb_req && wb_we_i;
    wire learn_hit;
    wire [3:0] learn_chan;

    function [31:0] merge;
        input [31:0] old;
        input [31:0] din;
        input [3:0] sel;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (sel[i]) begin
                    merge[i*8 +: 8] = din[i*8 +: 8];
                end
            end
        end
    endfunction

    reg [31:0] next_cfg;
    always @* begin
        next_cfg = cfg;
        if (wb_wr && wb_adr_i == `MPRF_CFG_ADDR) begin
            next_cfg = merge(cfg, wb_dat_i, wb_sel_i);
        end
        if (learn_hit) begin
            next_cfg[`MPRF_CFG_CHAN_LSB +: 5] = {1'b0, learn_chan};
        end
        next_cfg[31:17] = 15'h0000;
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cfg <= `MPRF_CFG_RESET;
            sw <= `MPRF_SW_RESET;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            use_perf_pattern <= 1'b0;
            sysex_dump_start <= 1'b0;
        end else begin
            cfg <= next_cfg;
            if (wb_wr && wb_adr_i == `MPRF_SW_ADDR) begin
                sw <= merge(sw, wb_dat_i, wb_sel_i) & 32'h0000_3FFF;
            end
            wb_ack_o <= wb_req;
            if (wb_req && !wb_we_i) begin
                case (wb_adr_i)
                    `MPRF_CFG_ADDR: wb_dat_o <= cfg;
                    `MPRF_SW_ADDR: wb_dat_o <= sw;
                    `MPRF_STAT_ADDR: wb_dat_o <= {28'h000_0000, part_mute, arp_mute, arp_hold, env_sustain};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
            use_perf_pattern <= cfg[`MPRF_CFG_PAT_BIT];
            sysex_dump_start <= sysex_page_active && chan_button_press;
        end
    end

    // ----------------------------------------
    // Decode and channel match
    // ----------------------------------------
    wire dec_valid;
    wire [3:0] dec_type;
    wire [3:0] dec_chan;
    wire [6:0] dec_d1;
    wire [6:0] dec_d2;
    mprf_decode u_dec (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .msg_valid(msg_valid),
        .msg_status(msg_status),
        .msg_data1(msg_data1),
        .msg_data2(msg_data2),
        .dec_valid(dec_valid),
        .dec_type(dec_type),
        .dec_chan(dec_chan),
        .dec_d1(dec_d1),
        .dec_d2(dec_d2)
    );

    reg chan_match;
    always @* begin
        if (part_channel == `MPRF_CH_OMNI) begin
            chan_match = 1'b1;
        end else if (part_channel == `MPRF_CH_GLOBAL) begin
            chan_match = (dec_chan == global_channel);
        end else begin
            chan_match = (dec_chan == part_channel[3:0]);
        end
    end

    // Note-on with velocity above zero is a played note
    assign learn_hit = dec_valid && page_down_held && dec_type == `MPRF_ST_NOTE_ON && dec_d2 != 7'h00;
    assign learn_chan = dec_chan;

    wire is_cc = dec_valid && chan_match && dec_type == `MPRF_ST_CC;
    wire is_pc = dec_valid && chan_match && dec_type == `MPRF_ST_PC;
    wire is_bank = (dec_d1 == `MPRF_CC_BANK_MSB) || (dec_d1 == `MPRF_CC_BANK_LSB);
    // Bank select is governed by the program filter and global program enable only
    wire cc_pass = is_cc && (is_bank ? (!prog_filter && global_pc_en)
                                     : (!ctrl_filter && global_cc_en));
    wire pc_pass = is_pc && !prog_filter && global_pc_en;

    // ----------------------------------------
    // Footswitch events (local and received)
    // ----------------------------------------
    wire loc_fs1 = fsw_event && fsw_index == 2'd0 && sw_enable[0];
    wire loc_fs2 = fsw_event && fsw_index == 2'd1 && sw_enable[1];
    wire loc_fs3 = fsw_event && fsw_index == 2'd2 && sw_enable[2] && fs3_is_switch;
    wire loc_ped = pedal_event && sw_enable[2] && !fs3_is_switch;
    wire rx_on = dec_d2 >= `MPRF_CC_ON_MIN;
    wire rx_fs1 = cc_pass && dec_d1 == `MPRF_CC_FS1 + 7'h01;
    wire ev2 = loc_fs2 || (cc_pass && dec_d1 == `MPRF_CC_FS1);
    wire ev2_on = loc_fs2 ? fsw_on : rx_on;
    wire ev1 = loc_fs1 || rx_fs1;
    wire ev1_on = loc_fs1 ? fsw_on : rx_on;
    wire ev3 = loc_fs3 || (cc_pass && fs3_is_switch && dec_d1 == `MPRF_CC_FS3);
    wire ev3_on = loc_fs3 ? (fsw_on ^ (fs3_mode == `MPRF_FS3_SWITCH_I)) : rx_on;

    // Sustain/switch 2 response as footswitch code
    reg [3:0] sus_code;
    always @* begin
        case (sustain_switch2_response)
            `MPRF_SUS_ENABLE: sus_code = {1'b0, `MPRF_FS_SUSTAIN};
            `MPRF_SUS_HOLD: sus_code = {1'b0, `MPRF_FS_HOLD};
            `MPRF_SUS_AMUTE: sus_code = {1'b0, `MPRF_FS_AMUTE};
            `MPRF_SUS_PMUTE: sus_code = {1'b0, `MPRF_FS_PMUTE};
            `MPRF_SUS_ENABLE_I: sus_code = {1'b1, `MPRF_FS_SUSTAIN};
            `MPRF_SUS_HOLD_I: sus_code = {1'b1, `MPRF_FS_HOLD};
            `MPRF_SUS_PMUTE_I: sus_code = {1'b1, `MPRF_FS_PMUTE};
            default: sus_code = {1'b0, `MPRF_FS_OFF};
        endcase
    end

    wire [3:0] s2_a;
    wire [3:0] s1_a;
    wire [3:0] s3_a;
    wire l2;
    wire l1;
    wire l3;
    mprf_switch_map u_map2 (
        .ev_valid(ev2), .ev_on(ev2_on), .resp(sus_code),
        .set_sustain(s2_a[0]), .set_hold(s2_a[1]), .set_amute(s2_a[2]), .set_pmute(s2_a[3]), .level(l2)
    );
    mprf_switch_map u_map1 (
        .ev_valid(ev1), .ev_on(ev1_on), .resp(footswitch_one_response),
        .set_sustain(s1_a[0]), .set_hold(s1_a[1]), .set_amute(s1_a[2]), .set_pmute(s1_a[3]), .level(l1)
    );
    mprf_switch_map u_map3 (
        .ev_valid(ev3), .ev_on(ev3_on), .resp(footswitch_three_response),
        .set_sustain(s3_a[0]), .set_hold(s3_a[1]), .set_amute(s3_a[2]), .set_pmute(s3_a[3]), .level(l3)
    );

    // ----------------------------------------
    // Action state, events and transmit
    // ----------------------------------------
    wire ped_rx = cc_pass && !fs3_is_switch && pedal_rx && dec_d1 == `MPRF_CC_PEDAL;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            env_sustain <= 1'b0;
            arp_hold <= 1'b0;
            arp_mute <= 1'b0;
            part_mute <= 1'b0;
            prog_change_valid <= 1'b0;
            prog_change_num <= 7'h00;
            cc_valid <= 1'b0;
            cc_num <= 7'h00;
            cc_value <= 7'h00;
            tx_valid <= 1'b0;
            tx_status <= 8'h00;
            tx_data1 <= 7'h00;
            tx_data2 <= 7'h00;
        end else begin
            if (s2_a[0]) env_sustain <= l2;
            else if (s1_a[0]) env_sustain <= l1;
            else if (s3_a[0]) env_sustain <= l3;
            if (s2_a[1]) arp_hold <= l2;
            else if (s1_a[1]) arp_hold <= l1;
            else if (s3_a[1]) arp_hold <= l3;
            if (s2_a[2]) arp_mute <= l2;
            else if (s1_a[2]) arp_mute <= l1;
            else if (s3_a[2]) arp_mute <= l3;
            if (s2_a[3]) part_mute <= l2;
            else if (s1_a[3]) part_mute <= l1;
            else if (s3_a[3]) part_mute <= l3;
            prog_change_valid <= pc_pass;
            if (pc_pass) prog_change_num <= dec_d1;
            // Pedal data reaches the part only when enabled for it
            cc_valid <= (cc_pass && dec_d1 != `MPRF_CC_PEDAL) || ped_rx || (loc_ped && pedal_rx);
            if (loc_ped) begin
                cc_num <= `MPRF_CC_PEDAL;
                cc_value <= pedal_value;
            end else if (cc_pass) begin
                cc_num <= dec_d1;
                cc_value <= dec_d2;
            end
            tx_valid <= loc_fs1 || loc_fs2 || loc_fs3 || loc_ped;
            tx_status <= {`MPRF_ST_CC, (part_channel[4] ? global_channel : part_channel[3:0])};
            tx_data1 <= loc_ped ? `MPRF_CC_PEDAL : (loc_fs3 ? `MPRF_CC_FS3 : `MPRF_CC_FS1 + {6'h00, loc_fs1});
            tx_data2 <= loc_ped ? pedal_value : (fsw_on ? 7'h7F : 7'h00);
        end
    end
endmodule

/* sim/mprf_part_sva.sv */
// Purpose: Concurrent checks on the part receive filter ports
// Assumes: One clock domain; all outputs low while nrst is low
// Notes: Bound to every instance of the part
`timescale 1ns/10ps
`include "mprf_map.vh"
module mprf_part_sva (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    // Messages and panel
    input wire logic msg_valid,
    input wire logic [7:0] msg_status,
    input wire logic [6:0] msg_data1,
    input wire logic fsw_event,
    input wire logic pedal_event,
    input wire logic sysex_page_active,
    input wire logic chan_button_press,
    // Actions
    input wire logic prog_change_valid,
    input wire logic [6:0] prog_change_num,
    input wire logic cc_valid,
    input wire logic tx_valid,
    input wire logic [7:0] tx_status,
    input wire logic sysex_dump_start
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    // ----------------------------------------
    // Sequences
    // ----------------------------------------
    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    sequence s_dump_req;
        sysex_page_active && chan_button_press;
    endsequence
    a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> s_ack_pulse)
        else $error("ack not a one cycle pulse");
    a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    a_pc_source: assert property (prog_change_valid |-> $past(msg_valid, 2) && $past(msg_status[7:4], 2) == `MPRF_ST_PC)
        else $error("program change without a message");
    a_pc_number: assert property (prog_change_valid |-> prog_change_num == $past(msg_data1, 2))
        else $error("wrong program number");
    a_cc_source: assert property (cc_valid && !$past(fsw_event) && !$past(pedal_event)
        |-> $past(msg_valid, 2) && $past(msg_status[7:4], 2) == `MPRF_ST_CC)
        else $error("controller without a message");
    a_tx_cause: assert property (tx_valid |-> $past(fsw_event || pedal_event))
        else $error("transmit without a switch event");
    a_tx_status: assert property (tx_valid |-> tx_status[7:4] == `MPRF_ST_CC)
        else $error("transmitted status is not a controller");
    a_dump_follows: assert property (s_dump_req |=> sysex_dump_start)
        else $error("dump missed");
    a_dump_cause: assert property (sysex_dump_start |-> $past(sysex_page_active && chan_button_press))
        else $error("dump without a press");
endmodule
bind mprf_part mprf_part_sva u_mprf_part_sva (.*);

/* sim/mprf_seq.sv */
// Purpose: Sequencer model sending assembled channel messages
// Assumes: One message per one-cycle strobe
// Notes: Fields carry the inverse of the last message between strobes
`timescale 1ns/10ps
module mprf_seq (
    // Clock
    input wire logic clk_sys,
    // Message out
    output logic msg_valid,
    output logic [7:0] msg_status,
    output logic [6:0] msg_data1,
    output logic [6:0] msg_data2
);
    initial begin
        msg_valid = 1'b0;
        msg_status = 8'h00;
        msg_data1 = 7'h00;
        msg_data2 = 7'h00;
    end
    // Send one message, then stay idle for gap cycles
    task automatic send(input logic [7:0] st, input logic [6:0] d1, input logic [6:0] d2, input int gap);
        @(posedge clk_sys);
        msg_valid <= 1'b1;
        msg_status <= st;
        msg_data1 <= d1;
        msg_data2 <= d2;
        @(posedge clk_sys);
        msg_valid <= 1'b0;
        msg_status <= ~st;
        msg_data1 <= ~d1;
        msg_data2 <= ~d2;
        repeat (gap) @(posedge clk_sys);
    endtask
endmodule

/* sim/tb.sv */
// Purpose: Self-checking bench for the part receive filter
// Assumes: Action levels settle two edges after a message
// Notes: Pulse outputs are counted as they occur
`timescale 1ns/10ps
`include "mprf_map.vh"
module tb;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
    logic [7:0] wb_adr_i = 8'h00, msg_status, tx_status, last_txs;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, q;
    logic msg_valid, page_down_held = 1'b0, sysex_page_active = 1'b0, chan_button_press = 1'b0;
    logic fsw_event = 1'b0, fsw_on = 1'b0, pedal_event = 1'b0;
    logic [1:0] fsw_index = 2'h0;
    logic [6:0] pedal_value = 7'h00, msg_data1, msg_data2, prog_change_num, cc_num, cc_value;
    logic [6:0] tx_data1, tx_data2, last_pc, last_cc, last_txd;
    logic env_sustain, arp_hold, arp_mute, part_mute, prog_change_valid, cc_valid;
    logic use_perf_pattern, sysex_dump_start, tx_valid;
    wire [3:0] act = {part_mute, arp_mute, arp_hold, env_sustain};
    int bad_count = 0, samples_checked = 0, n_pc = 0, n_cc = 0, n_tx = 0, n_dump = 0, k, m;
    localparam logic [3:0] sus_mask [8] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h1, 4'h2, 4'h8, 4'h0};
    always #10 clk_sys = ~clk_sys;
    mprf_part u_mprf_part (.*);
    mprf_seq u_mprf_seq (.*);
    // ----------------------------------------
    // Pulse capture and helpers
    // ----------------------------------------
    always @(posedge clk_sys) begin
        if (prog_change_valid === 1'b1) begin
            n_pc <= n_pc + 1;
            last_pc <= prog_change_num;
        end
        if (cc_valid === 1'b1) begin
            n_cc <= n_cc + 1;
            last_cc <= cc_num;
        end
        if (tx_valid === 1'b1) begin
            n_tx <= n_tx + 1;
            last_txs <= tx_status;
            last_txd <= tx_data1;
        end
        if (sysex_dump_start === 1'b1) n_dump <= n_dump + 1;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        @(posedge clk_sys);
        while (wb_ack_o !== 1'b1) @(posedge clk_sys);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0000_0000);
        chk(q, exp);
    endtask
    task automatic mi(input logic [7:0] st, input logic [6:0] d1, input logic [6:0] d2);
        u_mprf_seq.send(st, d1, d2, 3);
    endtask
    // Local switch or pedal event, one cycle wide
    task automatic fsw(input logic [1:0] idx, input logic on, input logic ped);
        @(posedge clk_sys);
        fsw_event <= ~ped;
        pedal_event <= ped;
        fsw_index <= idx;
        fsw_on <= on;
        pedal_value <= 7'h33;
        @(posedge clk_sys);
        fsw_event <= 1'b0;
        pedal_event <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask
    // Filter row: flags are global CC, global PC, ctrl filter, prog filter
    task automatic filt(input logic [3:0] fl, input logic pc, input logic [6:0] d1, input logic pass);
        int n0;
        wb(1'b1, `MPRF_CFG_ADDR, {16'h0000, fl, 12'hE00});
        n0 = pc ? n_pc : n_cc;
        mi(pc ? 8'hC0 : 8'hB0, d1, 7'h11);
        chk((pc ? n_pc : n_cc) - n0, pass);
        if (pass) chk(pc ? last_pc : last_cc, d1);
    endtask
    task automatic done_test(input string s);
        $display("test %s done", s);
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        #200_000;
        bad_count++;
        wrap_up();
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rd(`MPRF_CFG_ADDR, 32'h0000_C010);
        rd(`MPRF_SW_ADDR, 32'h0000_3800);
        wb(1'b1, 8'h10, 32'h0000_5555);
        rd(8'h10, 32'h0000_0000);
        done_test("registers");
        wb(1'b1, `MPRF_CFG_ADDR, 32'h0000_C002);
        mi(8'hB2, 7'h40, 7'h7F);
        chk(act, 4'h1);
        mi(8'hB3, 7'h40, 7'h00);
        rd(`MPRF_STAT_ADDR, 32'h0000_0001);
        mi(8'hB2, 7'h40, 7'h00);
        chk(act, 4'h0);
        wb(1'b1, `MPRF_CFG_ADDR, 32'h0000_C010);
        mi(8'hB9, 7'h40, 7'h7F);
        chk(act, 4'h1);
        mi(8'hB9, 7'h40, 7'h00);
        wb(1'b1, `MPRF_CFG_ADDR, 32'h0000_C0B1);
        mi(8'hB0, 7'h40, 7'h7F);
        chk(act, 4'h0);
        mi(8'hB5, 7'h40, 7'h7F);
        chk(act, 4'h1);
        mi(8'hB5, 7'h40, 7'h00);
        done_test("channel");
        for (k = 0; k < 8; k++) begin
            wb(1'b1, `MPRF_CFG_ADDR, {16'h0000, 4'hC, k[2:0], 9'h000});
            mi(8'hB0, 7'h40, (k inside {4, 5, 6}) ? 7'h00 : 7'h7F);
            chk(act, sus_mask[k]);
            mi(8'hB0, 7'h40, (k inside {4, 5, 6}) ? 7'h7F : 7'h00);
            chk(act, 4'h0);
        end
        done_test("sustain");
        page_down_held <= 1'b1;
        mi(8'h9A, 7'h3C, 7'h40);
        rd(`MPRF_CFG_ADDR, 32'h0000_CE0A);
        mi(8'h9F, 7'h3C, 7'h40);
        page_down_held <= 1'b0;
        rd(`MPRF_CFG_ADDR, 32'h0000_CE0F);
        done_test("learn");
        filt(4'hC, 1'b1, 7'h05, 1'b1);
        filt(4'hD, 1'b1, 7'h05, 1'b0);
        filt(4'hD, 1'b0, 7'h00, 1'b0);
        filt(4'hD, 1'b0, 7'h20, 1'b0);
        filt(4'hD, 1'b0, 7'h07, 1'b1);
        filt(4'h8, 1'b1, 7'h05, 1'b0);
        filt(4'hE, 1'b0, 7'h07, 1'b0);
        filt(4'hE, 1'b0, 7'h00, 1'b1);
        filt(4'hE, 1'b0, 7'h20, 1'b1);
        filt(4'h4, 1'b0, 7'h07, 1'b0);
        filt(4'hC, 1'b0, 7'h07, 1'b1);
        done_test("filters");
        wb(1'b1, `MPRF_SW_ADDR, 32'h0000_3802);
        m = n_tx;
        fsw(2'h0, 1'b1, 1'b0);
        chk(act, 4'h2);
        chk(n_tx - m, 1);
        chk(last_txs, 8'hB0);
        fsw(2'h0, 1'b0, 1'b0);
        wb(1'b1, `MPRF_SW_ADDR, 32'h0000_380A);
        fsw(2'h0, 1'b0, 1'b0);
        chk(act, 4'h2);
        fsw(2'h0, 1'b1, 1'b0);
        wb(1'b1, `MPRF_SW_ADDR, 32'h0000_3002);
        m = n_tx;
        fsw(2'h0, 1'b1, 1'b0);
        chk({act, 28'(n_tx - m)}, 32'h0000_0000);
        wb(1'b1, `MPRF_SW_ADDR, 32'h0000_3830);
        fsw(2'h2, 1'b1, 1'b0);
        chk(act, 4'h4);
        fsw(2'h2, 1'b0, 1'b0);
        wb(1'b1, `MPRF_SW_ADDR, 32'h0000_3A30);
        fsw(2'h2, 1'b1, 1'b0);
        chk(act, 4'h0);
        for (k = 1; k >= 0; k--) begin
            wb(1'b1, `MPRF_SW_ADDR, k ? 32'h0000_3E00 : 32'h0000_1A00);
            m = n_cc;
            mi(8'hB0, 7'h02, 7'h33);
            chk(n_cc - m, k);
            m = n_tx;
            fsw(2'h2, 1'b0, 1'b1);
            chk(n_tx - m, k);
        end
        chk(last_txd, 7'h02);
        done_test("footswitch");
        wb(1'b1, `MPRF_CFG_ADDR, 32'h0001_C000);
        repeat (2) @(posedge clk_sys);
        chk(use_perf_pattern, 1'b1);
        wb(1'b1, `MPRF_CFG_ADDR, 32'h0000_C000);
        repeat (2) @(posedge clk_sys);
        chk(use_perf_pattern, 1'b0);
        for (k = 1; k >= 0; k--) begin
            sysex_page_active <= k[0];
            m = n_dump;
            @(posedge clk_sys);
            chan_button_press <= 1'b1;
            @(posedge clk_sys);
            chan_button_press <= 1'b0;
            repeat (3) @(posedge clk_sys);
            chk(n_dump - m, k);
        end
        done_test("pattern and dump");
        wrap_up();
    end
endmodule
